// ==== hw/dsar_regs.vh ====
// Constants for the dual setpoint alarm relay block
`ifndef DSAR_REGS_VH
`define DSAR_REGS_VH
`define DSAR_RDG_W 32
`define DSAR_ST_IDLE 4'h0
`define DSAR_ST_NOOPT 4'h1
`define DSAR_ST_ENA 4'h2
`define DSAR_ST_HLVL 4'h3
`define DSAR_ST_HSNS 4'h4
`define DSAR_ST_LLVL 4'h5
`define DSAR_ST_LSNS 4'h6
`define DSAR_ST_SRC 4'h7
`define DSAR_SENSE_OPEN 1'b0
`define DSAR_SENSE_CLOSE 1'b1
`define DSAR_SRC_LEFT 1'b0
`define DSAR_SRC_RIGHT 1'b1
`endif

// ==== hw/dsar_alarm.v ====
// Dual setpoint alarm relay logic with keypad configuration sequencer
`timescale 1ns/10ps
`include "dsar_regs.vh"
module dsar_alarm #(
    parameter W = `DSAR_RDG_W
) (
    input wire clk,
    input wire rstn,
    input wire power_down,
    input wire option_present,
    input wire setup_enter,
    input wire any_key,
    input wire cfg_valid,
    input wire [W-1:0] cfg_value,
    input wire cfg_bit,
    input wire signed [W-1:0] left_rdg,
    input wire left_rdg_valid,
    input wire signed [W-1:0] right_rdg,
    input wire right_rdg_valid,
    output wire relay1_closed,
    output wire relay2_closed,
    output wire armed,
    output wire option_missing,
    output wire [3:0] step,
    output wire signed [W-1:0] high_level,
    output wire signed [W-1:0] low_level,
    output wire high_sense,
    output wire low_sense,
    output wire source_right
);
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg armed_q;
    reg armed_d;
    reg option_missing_q;
    reg [3:0] step_q;
    reg signed [W-1:0] high_level_q;
    reg signed [W-1:0] high_level_d;
    reg signed [W-1:0] low_level_q;
    reg signed [W-1:0] low_level_d;
    reg high_sense_q;
    reg high_sense_d;
    reg low_sense_q;
    reg low_sense_d;
    reg source_right_q;
    reg source_right_d;
    wire signed [W-1:0] sel_rdg;
    wire sel_valid;

    assign armed = armed_q;
    assign option_missing = option_missing_q;
    assign step = step_q;
    assign high_level = high_level_q;
    assign low_level = low_level_q;
    assign high_sense = high_sense_q;
    assign low_sense = low_sense_q;
    assign source_right = source_right_q;

    assign sel_rdg = source_right ? right_rdg : left_rdg;
    assign sel_valid = source_right ? right_rdg_valid : left_rdg_valid;

    always @* begin
        state_d = state_q;
        case (state_q)
            `DSAR_ST_IDLE: begin
                if (setup_enter) begin
                    state_d = option_present ? `DSAR_ST_ENA : `DSAR_ST_NOOPT;
                end
            end
            `DSAR_ST_NOOPT: begin
                if (any_key) begin
                    state_d = `DSAR_ST_IDLE;
                end
            end
            `DSAR_ST_ENA: begin
                if (cfg_valid) begin
                    state_d = cfg_bit ? `DSAR_ST_HLVL : `DSAR_ST_IDLE;
                end
            end
            `DSAR_ST_HLVL: begin
                if (cfg_valid) begin
                    state_d = `DSAR_ST_HSNS;
                end
            end
            `DSAR_ST_HSNS: begin
                if (cfg_valid) begin
                    state_d = `DSAR_ST_LLVL;
                end
            end
            `DSAR_ST_LLVL: begin
                if (cfg_valid) begin
                    state_d = `DSAR_ST_LSNS;
                end
            end
            `DSAR_ST_LSNS: begin
                if (cfg_valid) begin
                    state_d = `DSAR_ST_SRC;
                end
            end
            `DSAR_ST_SRC: begin
                if (cfg_valid) begin
                    state_d = `DSAR_ST_IDLE;
                end
            end
            default: state_d = `DSAR_ST_IDLE;
        endcase
        if (power_down) begin
            state_d = `DSAR_ST_IDLE;
        end
    end

    // Settings follow the step that the enter press confirms
    always @* begin
        armed_d = armed_q;
        high_level_d = high_level_q;
        low_level_d = low_level_q;
        high_sense_d = high_sense_q;
        low_sense_d = low_sense_q;
        source_right_d = source_right_q;
        if (power_down) begin
            armed_d = 1'h0;
        end else if (cfg_valid) begin
            case (state_q)
                `DSAR_ST_ENA: begin
                    if (!cfg_bit) begin
                        armed_d = 1'h0;
                    end
                end
                `DSAR_ST_HLVL: begin
                    high_level_d = cfg_value;
                end
                `DSAR_ST_HSNS: begin
                    high_sense_d = cfg_bit;
                end
                `DSAR_ST_LLVL: begin
                    low_level_d = cfg_value;
                end
                `DSAR_ST_LSNS: begin
                    low_sense_d = cfg_bit;
                end
                `DSAR_ST_SRC: begin
                    source_right_d = cfg_bit;
                    armed_d = 1'h1;
                end
                default: begin
                    armed_d = armed_q;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            state_q <= `DSAR_ST_IDLE;
            armed_q <= 1'h0;
            option_missing_q <= 1'h0;
            step_q <= `DSAR_ST_IDLE;
            high_level_q <= {W{1'h0}};
            low_level_q <= {W{1'h0}};
            high_sense_q <= `DSAR_SENSE_OPEN;
            low_sense_q <= `DSAR_SENSE_OPEN;
            source_right_q <= `DSAR_SRC_LEFT;
        end else begin
            state_q <= state_d;
            step_q <= state_d;
            option_missing_q <= (state_d == `DSAR_ST_NOOPT);
            armed_q <= armed_d;
            high_level_q <= high_level_d;
            low_level_q <= low_level_d;
            high_sense_q <= high_sense_d;
            low_sense_q <= low_sense_d;
            source_right_q <= source_right_d;
        end
    end

    // Relay 1 watches the high level, relay 2 the low level
    dsar_relay_ch #(
        .W(W)
    ) dsar_relay_ch_hi_inst (
        .clk(clk),
        .rstn(rstn),
        .rdg(sel_rdg),
        .rdg_valid(sel_valid),
        .level(high_level_q),
        .sense(high_sense_q),
        .armed(armed_q),
        .relay_closed(relay1_closed)
    );

    dsar_relay_ch #(
        .W(W)
    ) dsar_relay_ch_lo_inst (
        .clk(clk),
        .rstn(rstn),
        .rdg(sel_rdg),
        .rdg_valid(sel_valid),
        .level(low_level_q),
        .sense(low_sense_q),
        .armed(armed_q),
        .relay_closed(relay2_closed)
    );
endmodule // dsar_alarm

// One alarm channel: trip compare, then contact sense
module dsar_relay_ch #(
    parameter W = `DSAR_RDG_W
) (
    input wire clk,
    input wire rstn,
    input wire signed [W-1:0] rdg,
    input wire rdg_valid,
    input wire signed [W-1:0] level,
    input wire sense,
    input wire armed,
    output wire relay_closed
);
    reg trip_q;
    reg trip_d;
    reg relay_q;
    reg relay_d;

    assign relay_closed = relay_q;

    // Trip is re-evaluated only on a fresh reading
    always @* begin
        trip_d = trip_q;
        if (rdg_valid) begin
            trip_d = rdg > level;
        end
    end

    // Open sense never closes; disarmed rests open
    always @* begin
        relay_d = armed & (sense == `DSAR_SENSE_CLOSE) & trip_q;
    end

    always @(posedge clk) begin
        if (!rstn) begin
            trip_q <= 1'h0;
            relay_q <= 1'h0;
        end else begin
            trip_q <= trip_d;
            relay_q <= relay_d;
        end
    end
endmodule // dsar_relay_ch

// ==== dv/dsar_alarm_props.sv ====
// Checker for the alarm relay block
`timescale 1ns/10ps
module dsar_alarm_props (
    input wire clk,
    input wire rstn,
    input wire power_down,
    input wire option_present,
    input wire setup_enter,
    input wire cfg_valid,
    input wire cfg_bit,
    input wire [31:0] cfg_value,
    input wire signed [31:0] left_rdg,
    input wire left_rdg_valid,
    input wire signed [31:0] right_rdg,
    input wire right_rdg_valid,
    input wire relay1_closed,
    input wire relay2_closed,
    input wire armed,
    input wire option_missing,
    input wire [3:0] step,
    input wire signed [31:0] high_level,
    input wire signed [31:0] low_level,
    input wire high_sense,
    input wire low_sense,
    input wire source_right
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire go = cfg_valid && !power_down;
    noopt_flag_a: assert property (setup_enter && step == 4'h0 && !option_present
        && !power_down |=> option_missing) else $error("noopt flag");
    en_step_a: assert property (go && step == 4'h2 && cfg_bit |=> step == 4'h3)
        else $error("en");
    dis_idle_a: assert property (go && step == 4'h2 && !cfg_bit
        |=> !armed && step == 4'h0) else $error("dis");
    hi_store_a: assert property (go && step == 4'h3 |=> high_level == $past(cfg_value))
        else $error("hlvl");
    lo_store_a: assert property (go && step == 4'h5 |=> low_level == $past(cfg_value))
        else $error("llvl");
    lo_sense_a: assert property (go && step == 4'h6 |=> low_sense == $past(cfg_bit))
        else $error("lsns");
    arm_src_a: assert property (go && step == 4'h7
        |=> armed && source_right == $past(cfg_bit)) else $error("arm");
    pd_clear_a: assert property (power_down |=> !armed) else $error("pd");
    idle_open_a: assert property (!armed [*3] |-> !relay1_closed && !relay2_closed)
        else $error("idle");
    hi_open_a: assert property (!high_sense |=> !relay1_closed) else $error("hopen");
    hi_trip_a: assert property ((!source_right && left_rdg_valid
        && left_rdg > high_level) ##1 (armed && high_sense) |-> ##1 relay1_closed)
        else $error("trip");
    lo_trip_a: assert property ((source_right && right_rdg_valid
        && right_rdg > low_level) ##1 (armed && low_sense) |-> ##1 relay2_closed)
        else $error("lo trip");
    cover property (armed && relay1_closed);
    cover property (armed && relay2_closed);
    cover property (option_missing);
    cover property (source_right && relay2_closed);
endmodule // dsar_alarm_props

// ==== dv/dsar_load.sv ====
// Annunciator load on the two relay contacts
`timescale 1ns/10ps
module dsar_load (
    input wire relay1_closed,
    input wire relay2_closed,
    output wire hi_lamp,
    output wire lo_lamp
);
    assign hi_lamp = relay1_closed;
    assign lo_lamp = relay2_closed;
endmodule // dsar_load

// ==== dv/tb_top.sv ====
// Bench for the alarm relay block
`timescale 1ns/10ps
module tb_top;
    reg clk = 0, rstn = 0, pd = 0, opt = 0, se = 0, ak = 0, cv = 0, cb = 0, lv = 0, rv = 0;
    reg [31:0] val = 0, lr = 0, rr = 0;
    wire r1, r2, arm, om, hq, lq;
    wire [31:0] hl;
    integer n_mismatch = 0, n_tests = 0, cyc = 0;
    always #50 clk = ~clk;
    dsar_alarm dsar_alarm_inst (.clk(clk), .rstn(rstn), .power_down(pd), .option_present(opt),
        .setup_enter(se), .any_key(ak), .cfg_valid(cv), .cfg_value(val), .cfg_bit(cb),
        .left_rdg(lr), .left_rdg_valid(lv), .right_rdg(rr), .right_rdg_valid(rv),
        .relay1_closed(r1), .relay2_closed(r2), .armed(arm), .option_missing(om), .step(),
        .high_level(hl), .low_level(), .high_sense(), .low_sense(), .source_right());
    dsar_load dsar_load_inst (.relay1_closed(r1), .relay2_closed(r2), .hi_lamp(hq), .lo_lamp(lq));
    task chk(input [39:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                $display("[ERR] %0s exp %h got %h", nm, e, g);
                n_mismatch = n_mismatch + 1;
            end
        end
    endtask
    task cfg(input b, input [31:0] v);
        begin
            @(posedge clk) begin cv <= 1; cb <= b; val <= v; end
            @(posedge clk) cv <= 0;
        end
    endtask
    task setup(input e, input [31:0] h, input a, input [31:0] l, input b, input s);
        begin
            @(posedge clk) se <= 1;
            @(posedge clk) se <= 0;
            cfg(e, 0);
            if (e) begin cfg(0, h); cfg(a, 0); cfg(0, l); cfg(b, 0); cfg(s, 0); end
            @(negedge clk);
        end
    endtask
    task rd(input [31:0] l, input [31:0] r, input [1:0] vm, input e1, input e2);
        begin
            @(posedge clk) begin lv <= vm[0]; rv <= vm[1]; lr <= l; rr <= r; end
            @(posedge clk) begin lv <= 0; rv <= 0; end
            repeat (2) @(posedge clk);
            @(negedge clk) chk("hiRly", e1, hq);
            chk("loRly", e2, lq);
        end
    endtask
    task summarize;
        begin
            $display("tests %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 1000) begin n_mismatch = n_mismatch + 1; summarize; end
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1;
        @(posedge clk) se <= 1;
        @(posedge clk) se <= 0;
        @(negedge clk) chk("noopt", 1, om);
        @(posedge clk) ak <= 1;
        @(posedge clk) begin ak <= 0; opt <= 1; end
        @(negedge clk) chk("noopt", 0, om);
        rd(8'hB, 8'hB, 3, 0, 0);
        setup(1, 8'hA, 1, 8'h1, 1, 0);
        chk("armed", 1, arm);
        chk("hlvl", 8'hA, hl);
        rd(8'hB, 8'h0, 3, 1, 1);
        rd(8'hA, 8'h32, 3, 0, 1);
        rd(8'h0, 8'h32, 2, 0, 1);
        rd(8'h1, 8'h0, 1, 0, 0);
        setup(1, 8'hA, 0, 32'hFFFFFFFB, 1, 1);
        rd(8'h0, 8'hB, 2, 0, 1);
        setup(0, 0, 0, 0, 0, 0);
        rd(8'h0, 8'hB, 2, 0, 0);
        setup(1, 8'hA, 1, 8'h1, 1, 1);
        @(posedge clk) pd <= 1;
        @(posedge clk) pd <= 0;
        @(negedge clk) chk("armed", 0, arm);
        rd(8'h0, 8'hB, 2, 0, 0);
        setup(1, 8'hA, 1, 8'h1, 0, 0);
        rd(8'hB, 8'h0, 1, 1, 0);
        summarize;
    end
endmodule // tb_top
bind dsar_alarm dsar_alarm_props dsar_alarm_props_inst (.*);
